// [common/sram_port_pkg.sv]
// constants for the synchronous burst sram port logic
package sram_port_pkg;
  localparam int ADDR_W_DEF  = 8;
  localparam int DATA_W_DEF  = 32;
  localparam int LANES_DEF   = 4;
  localparam int BURST_W     = 2;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic       RD_PIPE_RESET = 1'b0;
endpackage : sram_port_pkg

// [logic/sync_burst_sram_port.sv]
// pin-level control logic of a pipelined synchronous burst sram
`timescale 1ns/1ps
module sync_burst_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEF,
  parameter int LANES  = sram_port_pkg::LANES_DEF
) (
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic              pipeline_chip_select_n_in,
  input  wire logic              depth_select_high_in,
  input  wire logic              depth_select_low_n_in,
  input  wire logic              processor_addr_strobe_n_in,
  input  wire logic              controller_addr_strobe_n_in,
  input  wire logic              burst_advance_n_in,
  input  wire logic              global_write_n_in,
  input  wire logic              byte_write_enable_n_in,
  input  wire logic [LANES-1:0]  byte_lane_write_n_in,
  input  wire logic              output_enable_n_in,
  input  wire logic              sleep_request_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [DATA_W-1:0] dq_oe_n_out,
  output logic                   selected_out,
  output logic                   full_write_out,
  output logic      [LANES-1:0]  lane_write_out,
  output logic                   sleeping_out
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH  = 1 << ADDR_W;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0]        offs;
    logic              burst_active;
    logic              wr_active;
    logic              rd_stage;
    logic              rd_valid;
    logic              dq_drive;
    logic              sleeping;
    logic [DATA_W-1:0] q1;
    logic [DATA_W-1:0] q;
  } state_t;

  state_t st;
  state_t next_st;
  // read word of the addressed entry, one slice per lane
  wire logic [DATA_W-1:0] rd_word;

  logic              sel;
  logic              strobe;
  logic              full_wr;
  logic [LANES-1:0]  lane_wr;
  logic [ADDR_W-1:0] cur_addr;
  logic              wr_now;
  logic [ADDR_W-1:0] acc_addr;

  assign sel = !pipeline_chip_select_n_in && depth_select_high_in && !depth_select_low_n_in;
  // either strobe while deselected ends the burst and floats the bus
  assign strobe = !processor_addr_strobe_n_in || !controller_addr_strobe_n_in;

  assign full_wr = !global_write_n_in ||
                   (!byte_write_enable_n_in && (byte_lane_write_n_in == '0));
  assign lane_wr = !global_write_n_in ? {LANES{1'b1}} :
                   (!byte_write_enable_n_in ? ~byte_lane_write_n_in : '0);

  // burst address keeps the upper base and steps the low two bits
  assign cur_addr = {st.base[ADDR_W-1:sram_port_pkg::BURST_W],
                     st.base[sram_port_pkg::BURST_W-1:0] + st.offs};

  // address of this edge: a selected strobe takes the pins, advance takes the next beat
  // the step is done here so a write beat lands on the advanced address at once
  assign acc_addr = (strobe && sel) ? addr_in :
                    (st.burst_active && !burst_advance_n_in) ?
                    {st.base[ADDR_W-1:sram_port_pkg::BURST_W],
                     st.base[sram_port_pkg::BURST_W-1:0] + st.offs + 2'h1} :
                    cur_addr;

  // processor strobe always means read, so it can never overlap a write beat
  assign wr_now = (|lane_wr) && !sleep_request_in && processor_addr_strobe_n_in &&
                  ((st.wr_active && !strobe) || (sel && !controller_addr_strobe_n_in));

  always_comb begin
    next_st = st;
    next_st.rd_stage = 1'b0;
    next_st.rd_valid = st.rd_stage;
    // two register stages give the pipelined read latency
    next_st.q1 = rd_word;
    next_st.q = st.q1;
    next_st.sleeping = sleep_request_in;
    if (sleep_request_in) begin
      next_st.burst_active = 1'b0;
      next_st.wr_active = 1'b0;
      next_st.dq_drive = 1'b0;
    end else if (strobe && sel) begin
      next_st.base = addr_in;
      next_st.offs = sram_port_pkg::BURST_RESET;
      next_st.burst_active = 1'b1;
      next_st.wr_active = !processor_addr_strobe_n_in ? 1'b0 : (|lane_wr);
      if (processor_addr_strobe_n_in && (|lane_wr)) begin
        next_st.dq_drive = 1'b0;
      end else begin
        // only a new read strobe re-enables the drivers
        next_st.rd_stage = 1'b1;
        next_st.dq_drive = 1'b1;
      end
    end else if (strobe && !sel) begin
      next_st.burst_active = 1'b0;
      next_st.wr_active = 1'b0;
      next_st.dq_drive = 1'b0;
    end else if (st.burst_active && !burst_advance_n_in) begin
      // advance steps and wraps after the fourth beat
      next_st.offs = st.offs + 2'h1;
      next_st.rd_stage = !st.wr_active;
    end else if (st.burst_active) begin
      next_st.rd_stage = !st.wr_active && !wr_now;
    end
    if (wr_now) begin
      next_st.dq_drive = 1'b0;
      next_st.wr_active = 1'b1;
    end
    // leaving sleep the drivers stay off
    if (st.sleeping && !sleep_request_in) begin
      next_st.dq_drive = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // memory array carries no reset
  generate
    for (genvar i = 0; i < LANES; i++) begin : g_lane
      // each lane owns its array, so no array has two writing processes
      logic [LANE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge sys_clk_in) begin
        if (!srst_in && wr_now && lane_wr[i]) begin
          lane_mem[acc_addr] <= dq_in[i*LANE_W +: LANE_W];
        end
      end
      assign rd_word[i*LANE_W +: LANE_W] = lane_mem[acc_addr];
    end
  endgenerate

  always_comb begin
    dq_out = st.q;
    dq_oe_n_out = (st.dq_drive && st.rd_valid && !output_enable_n_in && !st.sleeping) ?
                  '0 : {DATA_W{1'b1}};
  end
  assign selected_out   = sel;
  assign full_write_out = full_wr;
  assign lane_write_out = lane_wr;
  assign sleeping_out   = st.sleeping;

  a_select_decode: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (pipeline_chip_select_n_in || !depth_select_high_in || depth_select_low_n_in) |-> !selected_out)
    else $error("selected with an enable inactive");
  a_select_all: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    selected_out |-> (!pipeline_chip_select_n_in && depth_select_high_in && !depth_select_low_n_in))
    else $error("select without all enables");
  a_global_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !global_write_n_in |-> (full_write_out && lane_write_out == {LANES{1'b1}}))
    else $error("global write not full width");
  a_lane_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (global_write_n_in && !byte_write_enable_n_in && byte_lane_write_n_in == '0) |-> full_write_out)
    else $error("all lanes not full write");
  sequence s_write_cycle;
    wr_now;
  endsequence
  a_float_after_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_write_cycle ##1 (!strobe)[*2] |-> &dq_oe_n_out)
    else $error("bus driven after write without read strobe");
  a_sleep_float: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $fell(sleep_request_in) |=> (&dq_oe_n_out))
    else $error("bus driven on sleep exit");
  a_burst_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st.burst_active && burst_advance_n_in && !strobe && !sleep_request_in) |=> $stable(st.offs))
    else $error("burst moved while suspended");
  a_burst_wrap: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st.burst_active && st.offs == 2'h3 && !burst_advance_n_in && !strobe && !sleep_request_in)
    |=> st.offs == 2'h0)
    else $error("burst did not wrap");

  // read start: selected processor strobe, awake and not just out of sleep
  sequence s_read_start;
    sel && !processor_addr_strobe_n_in && !sleep_request_in && !sleeping_out;
  endsequence
  // a quiet beat: no strobe, no sleep, no lane write
  sequence s_quiet_beat;
    !strobe && !sleep_request_in && !(|lane_wr);
  endsequence
  a_read_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_read_start ##1 s_quiet_beat ##1 (!output_enable_n_in && !sleep_request_in) |-> dq_oe_n_out == '0)
    else $error("read strobe did not turn drivers on");
  a_write_float: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_write_cycle |=> &dq_oe_n_out)
    else $error("bus driven right after write");
  a_deselect_float: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (strobe && !sel && !sleep_request_in) |=> &dq_oe_n_out)
    else $error("bus driven after deselect strobe");
  a_sleep_copy: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    1'b1 |=> sleeping_out == $past(sleep_request_in))
    else $error("sleep state does not follow request");
endmodule : sync_burst_sram_port

// [bench/ctl_model.sv]
// memory controller model that drives the sram port pins
`timescale 1ns/1ps
module ctl_model (
  input  wire logic        sys_clk_in,
  output logic             cs_n_out,
  output logic             dhi_out,
  output logic             dlo_n_out,
  output logic             pstb_n_out,
  output logic             cstb_n_out,
  output logic             step_n_out,
  output logic             allw_n_out,
  output logic             we_n_out,
  output logic [3:0]       lanes_n_out,
  output logic             oe_n_out,
  output logic             sleep_out,
  output logic [7:0]       addr_out,
  output logic [31:0]      dq_out
);
  initial begin
    {cs_n_out, dhi_out, dlo_n_out} = 3'h4;
    {pstb_n_out, cstb_n_out, step_n_out, allw_n_out, we_n_out} = 5'h1f;
    {lanes_n_out, oe_n_out, sleep_out, addr_out, dq_out} = {4'hf, 2'h0, 8'h0, 32'h0};
  end
  // one bus cycle; pins move 1 ns after the edge and hold until the next call
  task automatic cyc(input logic [2:0] ce, input logic [4:0] c, input logic [3:0] ln, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    #1;
    {cs_n_out, dhi_out, dlo_n_out} = ce;
    {pstb_n_out, cstb_n_out, step_n_out, allw_n_out, we_n_out} = c;
    {lanes_n_out, addr_out} = {ln, a};
    // a released data bus must not keep showing the last value
    dq_out = (ln === 4'hf && c[1]) ? ~dq_out : d;
  endtask : cyc
  task automatic nap(input logic on);
    cyc(3'h4, 5'h1f, 4'hf, 8'h0, 32'h0);
    @(posedge sys_clk_in);
    #1;
    sleep_out = on;
  endtask : nap
endmodule : ctl_model

// [bench/tb_top.sv]
// self-checking bench for the sram port control logic
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cs_n, dhi, dlo_n, pstb_n, cstb_n, step_n, allw_n, we_n, oe_n, sleep, sel, fw, slp;
  logic [3:0] lanes_n, lw;
  logic [7:0] addr;
  logic [31:0] dq_i, dq_o, oe_o;
  int errors = 0;
  int n_tests = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  ctl_model ctl (.sys_clk_in(sys_clk_in), .cs_n_out(cs_n), .dhi_out(dhi), .dlo_n_out(dlo_n),
    .pstb_n_out(pstb_n), .cstb_n_out(cstb_n), .step_n_out(step_n), .allw_n_out(allw_n), .we_n_out(we_n),
    .lanes_n_out(lanes_n), .oe_n_out(oe_n), .sleep_out(sleep), .addr_out(addr), .dq_out(dq_i));
  sync_burst_sram_port DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pipeline_chip_select_n_in(cs_n),
    .depth_select_high_in(dhi), .depth_select_low_n_in(dlo_n), .processor_addr_strobe_n_in(pstb_n),
    .controller_addr_strobe_n_in(cstb_n), .burst_advance_n_in(step_n), .global_write_n_in(allw_n),
    .byte_write_enable_n_in(we_n), .byte_lane_write_n_in(lanes_n), .output_enable_n_in(oe_n),
    .sleep_request_in(sleep), .addr_in(addr), .dq_in(dq_i), .dq_out(dq_o), .dq_oe_n_out(oe_o),
    .selected_out(sel), .full_write_out(fw), .lane_write_out(lw), .sleeping_out(slp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic t_select();
    for (int i = 0; i < 8; i++) begin
      ctl.cyc(3'(i), 5'h1f, 4'hf, 8'h0, 32'h0);
      #1 chk(32'(sel), 32'(i == 2));
    end
  endtask : t_select
  task automatic t_fullw();
    ctl.cyc(3'h2, 5'h1e, 4'hf, 8'h0, 32'h0);
    #1 chk(32'(fw), 32'h0);
    ctl.cyc(3'h2, 5'h1d, 4'hf, 8'h0, 32'h0);
    #1 chk(32'(fw), 32'h1);
    chk(32'(lw), 32'hf);
    ctl.cyc(3'h2, 5'h1e, 4'h0, 8'h0, 32'h0);
    #1 chk(32'(fw), 32'h1);
    ctl.cyc(3'h2, 5'h1e, 4'h6, 8'h0, 32'h0);
    #1 chk(32'(fw), 32'h0);
    chk(32'(lw), 32'h9);
  endtask : t_fullw
  // write a four-beat burst, then read it back with one held beat and the wrap
  task automatic t_burst();
    logic [4:0] c [8] = '{5'h0f, 5'h1b, 5'h1f, 5'h1b, 5'h1b, 5'h1b, 5'h1f, 5'h1f};
    logic [7:0] a [6] = '{8'h10, 8'h11, 8'h11, 8'h12, 8'h13, 8'h10};
    for (int i = 0; i < 4; i++) ctl.cyc(3'h2, i ? 5'h19 : 5'h15, 4'hf, 8'h10, {24'h5a5a5a, 8'(8'h10 + i)});
    repeat (3) ctl.cyc(3'h2, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, '1);
    for (int j = 0; j < 8; j++) begin
      ctl.cyc(3'h2, c[j], 4'hf, 8'h10, 32'h0);
      if (j > 1) chk(dq_o, {24'h5a5a5a, a[j-2]});
      if (j > 1) chk(oe_o, 32'h0);
    end
  endtask : t_burst
  task automatic t_sleep();
    ctl.nap(1'b1);
    repeat (3) ctl.cyc(3'h4, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(32'(slp), 32'h1);
    ctl.nap(1'b0);
    repeat (2) ctl.cyc(3'h4, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, '1);
    chk(32'(slp), 32'h0);
  endtask : t_sleep
  // a deselected strobe and a reset in mid-run must both float a driving bus
  task automatic t_drop();
    ctl.cyc(3'h2, 5'h0f, 4'hf, 8'h10, 32'h0);
    repeat (2) ctl.cyc(3'h2, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, 32'h0);
    chk(dq_o, 32'h5a5a5a10);
    ctl.cyc(3'h4, 5'h0f, 4'hf, 8'h0, 32'h0);
    ctl.cyc(3'h2, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, '1);
    ctl.cyc(3'h2, 5'h0f, 4'hf, 8'h10, 32'h0);
    repeat (2) ctl.cyc(3'h2, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, 32'h0);
    srst_in = 1'b1;
    @(posedge sys_clk_in);
    #1 chk(oe_o, '1);
    srst_in = 1'b0;
    ctl.cyc(3'h2, 5'h1f, 4'hf, 8'h0, 32'h0);
    chk(oe_o, '1);
    chk(32'(slp), 32'h0);
  endtask : t_drop
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    chk(oe_o, '1);
    t_select();
    t_fullw();
    t_burst();
    t_sleep();
    t_drop();
    report_and_stop();
  end
endmodule : tb_top
